// ===== rtl/uft_pkg.sv
// Constants, register map and shared helpers of the UART data path core.
// How it works
// - Send LSB first with start/parity/stop framing
// - Holding write stores byte, advances FIFO pointer
// - Non-FIFO: holding-empty sets when byte moves
// - Transmit-empty interrupt only when mask bit1 set
// - Non-FIFO: shifter-empty sets after last bit
// - FIFO mode: 16 bytes; bit5 when FIFO empty
// - FIFO mode: tx interrupt below trigger level
// - FIFO mode: bit6 needs FIFO and shifter empty
// - Start bit sampled after 8 ticks, else discarded
// - Data and stop bits sampled mid-bit
// - Error tags follow head byte after each read
// - Receive FIFO 16 deep, 11 bits wide
// - Rx interrupt per char or trigger, mask bit0
// - Timeout after four words plus 12 bits
// - Special features need mask bit5
// - Soft reset bit ORed into reset output only
// - Power down halts, registers kept
// - Special mode: status bits 5:4 show inverted readiness
// - Loopback routes transmit shifter into receiver
// - Loopback: line mark, modem outputs off, inputs ignored
// - Three address lines plus divisor latch select
// - Each transmitted bit lasts 16 ticks
// - Block mode rx ready: trigger/timeout, clears empty
package uft_pkg;
  // ==========================================================
  // Register addresses
  localparam logic [2:0] A_DATA = 3'h0;
  localparam logic [2:0] A_IER  = 3'h1;
  localparam logic [2:0] A_ISR  = 3'h2;
  localparam logic [2:0] A_LCR  = 3'h3;
  localparam logic [2:0] A_MCR  = 3'h4;
  localparam logic [2:0] A_LSR  = 3'h5;
  localparam logic [2:0] A_MSR  = 3'h6;
  localparam logic [2:0] A_SPR  = 3'h7;
  // ==========================================================
  // Field positions
  localparam int IER_RX = 0, IER_TX = 1, IER_LS = 2, IER_SP = 5;
  localparam int FCR_EN = 0, FCR_RXF = 1, FCR_TXF = 2, FCR_DMA = 3;
  localparam int LCR_STOP = 2, LCR_PEN = 3, LCR_EVEN = 4, LCR_STK = 5, LCR_BRK = 6, LCR_DLAB = 7;
  localparam int MCR_DTR = 0, MCR_RTS = 1, MCR_SRST = 2, MCR_LOOP = 4, MCR_PD = 7;
  // ==========================================================
  // Reset values and timing
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_DIV = 8'h01;
  localparam int         OSR      = 16;   // Ticks per bit
  localparam int         HALF_BIT = 8;    // Ticks to start-bit centre
  localparam int         TO_WORDS = 4;
  localparam int         TO_EXTRA = 12;
  localparam logic [3:0] ISR_NONE = 4'h1, ISR_LS = 4'h6, ISR_RD = 4'h4, ISR_TO = 4'hC, ISR_TX = 4'h2;
  // ==========================================================
  // Trigger levels and parity
  function automatic logic [4:0] rx_trig(input logic [1:0] s);
    rx_trig = (s == 2'h0) ? 5'h01 : (s == 2'h1) ? 5'h04 : (s == 2'h2) ? 5'h08 : 5'h0E;
  endfunction
  function automatic logic [4:0] tx_trig(input logic [1:0] s);
    tx_trig = (s == 2'h0) ? 5'h01 : (s == 2'h1) ? 5'h04 : (s == 2'h2) ? 5'h08 : 5'h0C;
  endfunction
  // Stick parity forces the bit; otherwise even/odd over the data
  function automatic logic par_bit(input logic x, input logic [7:0] line_format_control);
    par_bit = line_format_control[LCR_STK] ? ~line_format_control[LCR_EVEN] : (x ^ ~line_format_control[LCR_EVEN]);
  endfunction
endpackage

// ===== rtl/uft_core.sv
// FIFO and UART data path core with register port.
`timescale 1ns/1ps
// ==========================================================
// Simple FIFO; depth must be a power of two so pointers wrap
module uft_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  input  wire logic                 flush_i,
  input  wire logic                 in_valid_i,
  output logic                      in_ready_o,
  input  wire logic [W-1:0]         in_data_i,
  output logic                      out_valid_o,
  input  wire logic                 out_ready_i,
  output logic [W-1:0]              out_data_o,
  output logic [$clog2(D):0]        level_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;
  assign in_ready_o  = (cnt_r != (AW+1)'(D));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem[rp_r];
  assign level_o     = cnt_r;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  // Storage has no reset; a data register read while empty still returns mem[rp_r]
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_r] <= in_data_i;
    end
  end
  // Pointers and fill count
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || flush_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= push ? wp_r + 1'b1 : wp_r;
      rp_r  <= pop ? rp_r + 1'b1 : rp_r;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==========================================================
// UART core
module uft_core import uft_pkg::*; #(
  parameter int TX_DEPTH = 16,
  parameter int RX_DEPTH = 16
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       cs_i,
  input  wire logic       rd_i,
  input  wire logic       wr_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  input  wire logic       rx_i,
  output logic            tx_o,
  output logic            rts_b_o,
  output logic            dtr_b_o,
  input  wire logic       cts_b_i,
  input  wire logic       dsr_b_i,
  input  wire logic       ri_b_i,
  input  wire logic       cd_b_i,
  output logic            rst_out_o,
  output logic            irq_o
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001, ST_START = 5'b00010, ST_DATA = 5'b00100, ST_PAR = 5'b01000, ST_STOP = 5'b10000
  } uft_st_t;

  logic [7:0] ier_r, lcr_r, mcr_r, spr_r, dll_r, dlm_r, rdata_r;
  logic       fen_r, dma_r;
  logic [1:0] rxt_r, txt_r;
  logic [15:0] bcnt_r;
  logic       tick, pd, spm, loop, dlab, wr, rd, wr_thr, rd_rhr;
  logic [3:0] wlen;
  logic [2:0] last_bit;

  assign wr       = cs_i & wr_i;
  assign rd       = cs_i & rd_i;
  assign dlab     = lcr_r[LCR_DLAB];
  assign wr_thr   = wr & (addr_i == A_DATA) & !dlab;
  assign rd_rhr   = rd & (addr_i == A_DATA) & !dlab;
  assign spm      = ier_r[IER_SP];
  assign pd       = spm & mcr_r[MCR_PD];
  assign loop     = mcr_r[MCR_LOOP];
  assign wlen     = 4'h5 + {2'b00, lcr_r[1:0]};
  assign last_bit = 3'h4 + {1'b0, lcr_r[1:0]};

  // ==========================================================
  // Register writes; power down leaves every value in place
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      ier_r <= RST_REG;
      lcr_r <= RST_REG;
      mcr_r <= RST_REG;
      spr_r <= RST_REG;
      dll_r <= RST_DIV;
      dlm_r <= RST_REG;
      fen_r <= 1'b0;
      dma_r <= 1'b0;
      rxt_r <= 2'h0;
      txt_r <= 2'h0;
    end else if (wr) begin
      unique case (addr_i)
        A_DATA: if (dlab) dll_r <= wdata_i;
        A_IER:  if (dlab) dlm_r <= wdata_i; else ier_r <= wdata_i & 8'h2F;
        A_ISR: begin
          fen_r <= wdata_i[FCR_EN];
          dma_r <= wdata_i[FCR_DMA];
          rxt_r <= wdata_i[7:6];
          txt_r <= spm ? wdata_i[5:4] : 2'h0;
        end
        A_LCR:  lcr_r <= wdata_i;
        A_MCR:  mcr_r <= wdata_i & 8'h9F;
        A_SPR:  spr_r <= wdata_i;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Baud tick: divisor 0 behaves as 1; halted in power down
  logic [15:0] div_m1;
  assign div_m1 = ({dlm_r, dll_r} == 16'h0000) ? 16'h0000 : {dlm_r, dll_r} - 16'h0001;
  assign tick   = !pd & (bcnt_r == div_m1);
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      bcnt_r <= 16'h0000;
    end else if (!pd) begin
      bcnt_r <= tick ? 16'h0000 : bcnt_r + 16'h0001;
    end
  end

  // ==========================================================
  // Transmit FIFO; one entry usable when queueing is off
  logic       txq_rdy, txq_vld, tx_take, txq_in;
  logic [7:0] txq_dat;
  logic [$clog2(TX_DEPTH):0] tx_lvl;
  uft_st_t    tx_st_r;
  assign txq_in  = wr_thr & (fen_r | (tx_lvl == '0));
  assign tx_take = txq_vld & (tx_st_r == ST_IDLE);
  uft_fifo #(.W(8), .D(TX_DEPTH)) u_txq (
    .clk_i      (core_clk_i),
    .rst_b_i    (rst_b_i),
    .flush_i    (wr & (addr_i == A_ISR) & wdata_i[FCR_TXF]),
    .in_valid_i (txq_in),
    .in_ready_o (txq_rdy),
    .in_data_i  (wdata_i),
    .out_valid_o(txq_vld),
    .out_ready_i(tx_st_r == ST_IDLE),
    .out_data_o (txq_dat),
    .level_o    (tx_lvl)
  );

  // ==========================================================
  // Transmit shifter
  logic [7:0] tx_sh_r;
  logic [3:0] tx_tk_r;
  logic [2:0] tx_bit_r;
  logic       tx_line_r, tx_par_r, tx_end, tx_ser;
  assign tx_end = tick & (tx_tk_r == 4'(OSR - 1));
  assign tx_ser = tx_line_r & !lcr_r[LCR_BRK];
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      tx_st_r   <= ST_IDLE;
      tx_sh_r   <= 8'h00;
      tx_tk_r   <= 4'h0;
      tx_bit_r  <= 3'h0;
      tx_line_r <= 1'b1;
      tx_par_r  <= 1'b0;
    end else begin
      if (tick) tx_tk_r <= tx_tk_r + 4'h1;
      unique case (tx_st_r)
        ST_IDLE: if (tx_take) begin
          tx_sh_r   <= txq_dat;
          tx_tk_r   <= 4'h0;
          tx_line_r <= 1'b0;
          tx_st_r   <= ST_START;
        end
        ST_START: if (tx_end) begin
          tx_line_r <= tx_sh_r[0];
          tx_par_r  <= tx_sh_r[0];
          tx_sh_r   <= {1'b0, tx_sh_r[7:1]};
          tx_bit_r  <= 3'h0;
          tx_st_r   <= ST_DATA;
        end
        ST_DATA: if (tx_end) begin
          if (tx_bit_r == last_bit) begin
            tx_line_r <= lcr_r[LCR_PEN] ? par_bit(tx_par_r, lcr_r) : 1'b1;
            tx_st_r   <= lcr_r[LCR_PEN] ? ST_PAR : ST_STOP;
            tx_bit_r  <= 3'h0;
          end else begin
            tx_line_r <= tx_sh_r[0];
            tx_par_r  <= tx_par_r ^ tx_sh_r[0];
            tx_sh_r   <= {1'b0, tx_sh_r[7:1]};
            tx_bit_r  <= tx_bit_r + 3'h1;
          end
        end
        ST_PAR: if (tx_end) begin
          tx_line_r <= 1'b1;
          tx_st_r   <= ST_STOP;
        end
        ST_STOP: if (tx_end) begin
          tx_bit_r <= tx_bit_r + 3'h1;
          if (tx_bit_r[0] | !lcr_r[LCR_STOP]) tx_st_r <= ST_IDLE;
        end
        default: tx_st_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Receive FIFO: 8 data bits plus break, framing, parity tags
  logic        rx_in, rx_prev_r, rx_push, rx_acc, rxq_rdy, rxq_vld;
  logic [10:0] rxq_dat, rx_word;
  logic [$clog2(RX_DEPTH):0] rx_lvl;
  assign rx_in  = loop ? tx_ser : rx_i;
  assign rx_acc = rxq_rdy & (fen_r | (rx_lvl == '0));
  uft_fifo #(.W(11), .D(RX_DEPTH)) u_rxq (
    .clk_i      (core_clk_i),
    .rst_b_i    (rst_b_i),
    .flush_i    (wr & (addr_i == A_ISR) & wdata_i[FCR_RXF]),
    .in_valid_i (rx_push & rx_acc),
    .in_ready_o (rxq_rdy),
    .in_data_i  (rx_word),
    .out_valid_o(rxq_vld),
    .out_ready_i(rd_rhr),
    .out_data_o (rxq_dat),
    .level_o    (rx_lvl)
  );

  // ==========================================================
  // Receive shifter; a break only ends on a fresh falling edge
  uft_st_t    rx_st_r;
  logic [7:0] rx_sh_r;
  logic [3:0] rx_tk_r;
  logic [2:0] rx_bit_r;
  logic       rx_par_r, rx_pe_r, rx_one_r, rx_mid;
  assign rx_mid  = tick & (rx_tk_r == 4'(OSR - 1));
  assign rx_push = (rx_st_r == ST_STOP) & rx_mid;
  assign rx_word = {!rx_one_r & !rx_in, !rx_in, rx_pe_r, rx_sh_r >> (4'h8 - wlen)};
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      rx_st_r   <= ST_IDLE;
      rx_prev_r <= 1'b1;
      rx_sh_r   <= 8'h00;
      rx_tk_r   <= 4'h0;
      rx_bit_r  <= 3'h0;
      rx_par_r  <= 1'b0;
      rx_pe_r   <= 1'b0;
      rx_one_r  <= 1'b0;
    end else begin
      rx_prev_r <= rx_in;
      if (tick) rx_tk_r <= rx_tk_r + 4'h1;
      unique case (rx_st_r)
        ST_IDLE: if (rx_prev_r & !rx_in) begin
          rx_tk_r <= 4'h0;
          rx_st_r <= ST_START;
        end
        ST_START: if (tick & (rx_tk_r == 4'(HALF_BIT - 1))) begin
          rx_st_r  <= rx_in ? ST_IDLE : ST_DATA;
          rx_tk_r  <= 4'h0;
          rx_bit_r <= 3'h0;
          rx_par_r <= 1'b0;
          rx_pe_r  <= 1'b0;
          rx_one_r <= 1'b0;
        end
        ST_DATA: if (rx_mid) begin
          rx_sh_r  <= {rx_in, rx_sh_r[7:1]};
          rx_par_r <= rx_par_r ^ rx_in;
          rx_one_r <= rx_one_r | rx_in;
          rx_bit_r <= rx_bit_r + 3'h1;
          if (rx_bit_r == last_bit) rx_st_r <= lcr_r[LCR_PEN] ? ST_PAR : ST_STOP;
        end
        ST_PAR: if (rx_mid) begin
          rx_pe_r  <= rx_in != par_bit(rx_par_r, lcr_r);
          rx_one_r <= rx_one_r | rx_in;
          rx_st_r  <= ST_STOP;
        end
        ST_STOP: if (rx_mid) rx_st_r <= ST_IDLE;
        default: rx_st_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Overrun, time-out and block-mode receive readiness
  logic       ovr_r, to_r, rxblk_r;
  logic [9:0] to_cnt_r, to_lim;
  assign to_lim = {6'(TO_WORDS * wlen + TO_EXTRA), 4'h0};
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      ovr_r    <= 1'b0;
      to_r     <= 1'b0;
      to_cnt_r <= 10'h000;
      rxblk_r  <= 1'b0;
    end else begin
      // A new overrun beats the clear from the status read
      ovr_r <= (rx_push & !rx_acc) | (ovr_r & !(rd & (addr_i == A_LSR) & !dlab));
      if (rx_push | rd_rhr | !rxq_vld) begin
        to_cnt_r <= 10'h000;
        to_r     <= 1'b0;
      end else if (tick & !to_r) begin
        to_cnt_r <= to_cnt_r + 10'h001;
        to_r     <= (to_cnt_r == to_lim - 10'h001);
      end
      if (!rxq_vld) rxblk_r <= 1'b0;
      else if ((rx_lvl >= ($clog2(RX_DEPTH)+1)'(rx_trig(rxt_r))) | to_r) rxblk_r <= 1'b1;
    end
  end

  // ==========================================================
  // Status assembly
  logic [2:0] tags;
  logic [7:0] line_condition, interrupt_source, modem_line_condition;
  logic       txe_int, rxd_int, rx_rdy, tx_rdy;
  logic [3:0] code;
  assign tags    = rxq_vld ? rxq_dat[10:8] : 3'h0;
  assign line_condition     = {|tags, !txq_vld & (tx_st_r == ST_IDLE), !txq_vld, tags, ovr_r, rxq_vld};
  assign txe_int = fen_r ? (tx_lvl < ($clog2(TX_DEPTH)+1)'(tx_trig(txt_r))) : !txq_vld;
  assign rxd_int = fen_r ? (rx_lvl >= ($clog2(RX_DEPTH)+1)'(rx_trig(rxt_r))) : rxq_vld;
  assign rx_rdy  = (fen_r & dma_r) ? rxblk_r : rxq_vld;
  assign tx_rdy  = (fen_r & dma_r) ? txq_rdy : !txq_vld;
  assign modem_line_condition     = loop ? 8'h00 : {~cd_b_i, ~ri_b_i, ~dsr_b_i, ~cts_b_i, 4'h0};
  always_comb begin
    if (ier_r[IER_LS] & (ovr_r | |tags))  code = ISR_LS;
    else if (ier_r[IER_RX] & rxd_int)     code = ISR_RD;
    else if (ier_r[IER_RX] & to_r)        code = ISR_TO;
    else if (ier_r[IER_TX] & txe_int)     code = ISR_TX;
    else                                  code = ISR_NONE;
  end
  assign interrupt_source = {fen_r, fen_r, spm ? ~{rx_rdy, tx_rdy} : 2'b00, code};

  // ==========================================================
  // Read data, pins and reset output, all registered
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      rdata_r   <= 8'h00;
      tx_o      <= 1'b1;
      rts_b_o   <= 1'b1;
      dtr_b_o   <= 1'b1;
      rst_out_o <= 1'b1;
      irq_o     <= 1'b0;
    end else begin
      if (rd) begin
        unique case (addr_i)
          A_DATA:  rdata_r <= dlab ? dll_r : rxq_dat[7:0];
          A_IER:   rdata_r <= dlab ? dlm_r : ier_r;
          A_ISR:   rdata_r <= interrupt_source;
          A_LCR:   rdata_r <= lcr_r;
          A_MCR:   rdata_r <= mcr_r;
          A_LSR:   rdata_r <= line_condition;
          A_MSR:   rdata_r <= modem_line_condition;
          A_SPR:   rdata_r <= spr_r;
          default: rdata_r <= 8'h00;
        endcase
      end
      tx_o      <= loop | tx_ser;
      rts_b_o   <= loop | !mcr_r[MCR_RTS];
      dtr_b_o   <= loop | !mcr_r[MCR_DTR];
      rst_out_o <= spm & mcr_r[MCR_SRST];
      irq_o     <= (code != ISR_NONE);
    end
  end
  assign rdata_o = rdata_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_fall;
    (rx_st_r == ST_IDLE) && rx_prev_r && !rx_in;
  endsequence
  sequence s_false;
    (rx_st_r == ST_START) && tick && (rx_tk_r == 4'(HALF_BIT - 1)) && rx_in;
  endsequence
  AST_FALSE_START: assert property (s_fall ##[8:300] s_false |=> rx_st_r == ST_IDLE)
    else $error("false start not discarded");
  AST_START_SEEN: assert property (s_fall |=> rx_st_r == ST_START)
    else $error("falling edge not taken");
  AST_TEMT: assert property (line_condition[6] |-> (tx_lvl == '0) && (tx_st_r == ST_IDLE) && tx_line_r)
    else $error("transmitter empty while busy");
  AST_LOOP_PINS: assert property (loop |=> tx_o && rts_b_o && dtr_b_o)
    else $error("loopback pins not parked");
  AST_SOFT_RST: assert property (spm && mcr_r[MCR_SRST] |=> rst_out_o)
    else $error("soft reset not driven");
  AST_PD_HOLD: assert property (pd |-> !tick ##1 $stable(bcnt_r))
    else $error("baud runs in power down");
  AST_ISR_INV: assert property (spm |-> interrupt_source[5:4] == ~{(fen_r && dma_r) ? rxblk_r : (rx_lvl != '0),
    (fen_r && dma_r) ? (int'(tx_lvl) < TX_DEPTH) : (tx_lvl == '0)})
    else $error("ready bits not inverted");
  AST_THR_PUSH: assert property (wr_thr && fen_r && tx_lvl == '0 && !tx_take |=> tx_lvl == 1)
    else $error("holding write not stored");
  AST_TO_CAUSE: assert property ($rose(to_r) |-> $past(rxq_vld) && !$past(rd_rhr))
    else $error("timeout without waiting data");
  // Ticks since the last bit boundary, kept apart from the shifter's own count
  logic [4:0] ast_tk_r;
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || tx_take || tx_end) begin
      ast_tk_r <= 5'h00;
    end else if (tick && (ast_tk_r != 5'h1F)) begin
      ast_tk_r <= ast_tk_r + 5'h01;
    end
  end
  AST_TX_BIT: assert property ((tx_st_r != ST_IDLE) && tx_end |-> ast_tk_r == 5'h0F)
    else $error("bit not sixteen ticks long");
endmodule

// ===== dv/uft_far_end.sv
// Far-end serial device model: sends frames to the core and captures its 8-bit frames.
`timescale 1ns/1ps
// ==========================================================
// Far-end model
module uft_far_end (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  logic [7:0] got_q[$];  // Bytes captured from the core
  // Idle line is mark and stays there through loopback tests
  initial line_o = 1'b1;
  // One frame, 16 clocks a bit at divisor 1; parity bit only if asked
  task automatic send(input logic [7:0] d, input logic pen, input logic pv);
    logic [10:0] fr;
    fr = {1'b1, pv, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || pen) begin
        line_o <= fr[i];
        repeat (16) @(posedge clk_i);
      end
    end
  endtask
  // Short low pulse, too short to pass as a start bit
  task automatic glitch(input int n);
    line_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    line_o <= 1'b1;
  endtask
  // Capture at bit centres; only 8N1 is decoded, so tx tests use that format
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge line_i);
      repeat (8) @(posedge clk_i);
      if (line_i === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (16) @(posedge clk_i);
          b[i] = line_i;
        end
        repeat (16) @(posedge clk_i);
        got_q.push_back(b);
      end
    end
  end
endmodule

// ===== dv/uft_core_bench.sv
// Self-checking testbench of the UART data path core.
`timescale 1ns/1ps
// ==========================================================
// Bench top
module uft_core_bench import uft_pkg::*; ;
  logic       core_clk_i, rst_b_i, cs_i, rd_i, wr_i, rx_i, tx_o, cts_b_i;
  logic       rts_b_o, dtr_b_o, rst_out_o, irq_o;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o;
  int         n_errors, check_count;

  uft_core dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cs_i(cs_i), .rd_i(rd_i), .wr_i(wr_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rx_i(rx_i), .tx_o(tx_o), .rts_b_o(rts_b_o),
    .dtr_b_o(dtr_b_o), .cts_b_i(cts_b_i), .dsr_b_i(1'b1), .ri_b_i(1'b1), .cd_b_i(1'b1),
    .rst_out_o(rst_out_o), .irq_o(irq_o));
  uft_far_end far_u (.clk_i(core_clk_i), .line_i(tx_o), .line_o(rx_i));

  // 200 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Write: one strobe cycle, then one idle cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    cs_i <= 1'b1;
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    cs_i <= 1'b0;
    wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  // Read: data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    cs_i <= 1'b1;
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    cs_i <= 1'b0;
    rd_i <= 1'b0;
    #1 v = rdata_o;
    @(posedge core_clk_i);
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic timeout;
    n_errors++;
    $display("[FAIL] %0t wait bound used up", $time);
    results();
  endtask
  // Bounded wait for far-end captures
  task automatic wait_rx(input int n);
    for (int i = 0; i < 20000 && far_u.got_q.size() < n; i++) @(posedge core_clk_i);
    if (far_u.got_q.size() < n) timeout();
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    int zeros;
    rst_b_i = 1'b0;
    cs_i = 1'b0;
    rd_i = 1'b0;
    wr_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    cts_b_i = 1'b0;
    n_errors = 0;
    check_count = 0;
    repeat (5) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    // Reset state and register select
    rchk(A_LCR, 8'h00);
    rchk(A_LSR, 8'h60);
    rchk(A_MSR, 8'h10);
    #1 chk({6'h00, tx_o, rst_out_o}, 8'h02);
    wr(A_LCR, 8'h80);
    rchk(A_DATA, 8'h01);
    rchk(A_IER, 8'h00);
    wr(A_LCR, 8'h03);
    wr(A_SPR, 8'hA5);
    rchk(A_SPR, 8'hA5);
    // Holding register without FIFO
    wr(A_DATA, 8'h4B);
    @(posedge core_clk_i);
    rchk(A_LSR, 8'h20);
    wait_rx(1);
    chk(far_u.got_q[0], 8'h4B);
    repeat (16) @(posedge core_clk_i);
    rchk(A_LSR, 8'h60);
    // FIFO mode: back-to-back burst until the queue refuses
    wr(A_ISR, 8'h01);
    for (int i = 0; i < 20; i++) begin
      cs_i <= 1'b1;
      wr_i <= 1'b1;
      addr_i <= A_DATA;
      wdata_i <= 8'h10 + i[7:0];
      @(posedge core_clk_i);
    end
    cs_i <= 1'b0;
    wr_i <= 1'b0;
    @(posedge core_clk_i);
    rchk(A_LSR, 8'h00);
    wait_rx(18);
    for (int i = 0; i < 17; i++) chk(far_u.got_q[i + 1], 8'h10 + i[7:0]);
    repeat (16) @(posedge core_clk_i);
    chk(8'(far_u.got_q.size()), 8'h12);
    rchk(A_LSR, 8'h60);
    // Transmit interrupt follows its mask
    wr(A_IER, 8'h02);
    rchk(A_ISR, 8'hC2);
    #1 chk({7'h00, irq_o}, 8'h01);
    wr(A_IER, 8'h00);
    rchk(A_ISR, 8'hC1);
    #1 chk({7'h00, irq_o}, 8'h00);
    // Receive path, false start, parity tag
    far_u.send(8'hC3, 1'b0, 1'b0);
    rchk(A_DATA, 8'hC3);
    far_u.glitch(4);
    repeat (200) @(posedge core_clk_i);
    rchk(A_LSR, 8'h60);
    wr(A_LCR, 8'h1B);
    far_u.send(8'h01, 1'b1, 1'b0);
    far_u.send(8'h03, 1'b1, 1'b0);
    rchk(A_LSR, 8'hE5);
    rchk(A_DATA, 8'h01);
    rchk(A_LSR, 8'h61);
    rchk(A_DATA, 8'h03);
    wr(A_LCR, 8'h03);
    // Receive interrupt, trigger level 4 and time-out
    wr(A_ISR, 8'h41);
    wr(A_IER, 8'h01);
    far_u.send(8'h5A, 1'b0, 1'b0);
    rchk(A_ISR, 8'hC1);
    repeat (600) @(posedge core_clk_i);
    rchk(A_ISR, 8'hC1);
    for (int i = 0; i < 400 && irq_o !== 1'b1; i++) @(posedge core_clk_i);
    if (irq_o !== 1'b1) timeout();
    rchk(A_ISR, 8'hCC);
    rchk(A_DATA, 8'h5A);
    rchk(A_ISR, 8'hC1);
    for (int i = 0; i < 4; i++) far_u.send(8'h20 + i[7:0], 1'b0, 1'b0);
    rchk(A_ISR, 8'hC4);
    for (int i = 0; i < 4; i++) rchk(A_DATA, 8'h20 + i[7:0]);
    wr(A_IER, 8'h00);
    // Special mode: inverted readiness and soft reset output
    wr(A_IER, 8'h20);
    rchk(A_ISR, 8'hE1);
    wr(A_MCR, 8'h04);
    rchk(A_MCR, 8'h04);
    #1 chk({7'h00, rst_out_o}, 8'h01);
    rchk(A_SPR, 8'hA5);
    // Power down, then a write: the line freezes at the start bit, registers stay
    wr(A_MCR, 8'h84);
    wr(A_DATA, 8'h00);
    repeat (2) @(posedge core_clk_i);
    zeros = 0;
    repeat (250) begin
      @(posedge core_clk_i);
      if (tx_o === 1'b0) zeros++;
    end
    chk(8'(zeros), 8'hFA);
    rchk(A_LSR, 8'h20);
    rchk(A_MCR, 8'h84);
    wr(A_MCR, 8'h04);
    repeat (200) @(posedge core_clk_i);
    rchk(A_LSR, 8'h60);
    wr(A_IER, 8'h00);
    rchk(A_IER, 8'h00);
    #1 chk({7'h00, rst_out_o}, 8'h00);
    // Loopback: line held at mark, modem lines off
    wr(A_MCR, 8'h13);
    rchk(A_MSR, 8'h00);
    #1 chk({6'h00, rts_b_o, dtr_b_o}, 8'h03);
    wr(A_DATA, 8'h96);
    zeros = 0;
    repeat (200) begin
      @(posedge core_clk_i);
      if (tx_o !== 1'b1) zeros++;
    end
    chk(8'(zeros), 8'h00);
    rchk(A_DATA, 8'h96);
    wr(A_MCR, 8'h03);
    rchk(A_MCR, 8'h03);
    #1 chk({6'h00, rts_b_o, dtr_b_o}, 8'h00);
    results();
  end
endmodule
